/* File: common/hwm_consts.vh */
// Register map, field positions, reset values and timing for the monitor register bank.
// Assumes a 200 MHz core clock; included by the register bank only.
`ifndef HWM_CONSTS_VH
`define HWM_CONSTS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define HWM_ADDR_CHANNEL_MODE 8'h16
`define HWM_ADDR_CS2_HI 8'h35
`define HWM_ADDR_CS2_LO 8'h36
`define HWM_ADDR_RD1_HI 8'h37
`define HWM_ADDR_RD1_LO 8'h38
`define HWM_ADDR_IT_HI 8'h39
`define HWM_ADDR_IT_LO 8'h3a
`define HWM_ADDR_MI1_HI 8'h3b
`define HWM_ADDR_MI2_HI 8'h3c
`define HWM_ADDR_RSVD_3D 8'h3d
`define HWM_ADDR_MAKER 8'h3e
`define HWM_ADDR_REVISION 8'h3f
`define HWM_ADDR_MAIN_CONFIG 8'h40
`define HWM_ADDR_STATUS_A 8'h41
`define HWM_ADDR_STATUS_B 8'h42
`define HWM_ADDR_MASK_A 8'h43
`define HWM_ADDR_MASK_B 8'h44
`define HWM_ADDR_INTRUSION_CLR 8'h46
`define HWM_ADDR_VID_FANDIV 8'h47
`define HWM_ADDR_VID_HIGH 8'h49
`define HWM_ADDR_AUX_CONFIG 8'h4a
`define HWM_ADDR_STATUS_A_COPY 8'h4c
`define HWM_ADDR_STATUS_B_COPY 8'h4d

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define HWM_MODE_MI1_ANALOG 0
`define HWM_MODE_MI2_ANALOG 1
`define HWM_MODE_DIODE2 2
`define HWM_MODE_SUPPLY_5V 3
`define HWM_MODE_EXT_IRQ_A 4
`define HWM_MODE_EXT_IRQ_B 5
`define HWM_MODE_EXT_IRQ_C 6
`define HWM_MODE_ID_AS_IRQ 7
`define HWM_CFG_START 0
`define HWM_CFG_IRQ_ON 1
`define HWM_CFG_OVERTEMP_ON 2
`define HWM_CFG_IRQ_CLEAR 3
`define HWM_CFG_RESET_PULSE 4
`define HWM_CFG_OVERTEMP_RELEASE 6
`define HWM_CFG_INIT 7
`define HWM_AUX_THERMAL_MASK 0
`define HWM_STA_INT_TEMP 4
`define HWM_STA_RD1_TEMP 5
`define HWM_STB_CASE_OPEN 4
`define HWM_STB_OVERTEMP_IN 5
`define HWM_INTRUSION_CLR_BIT 7

// ----------------------------------------------------------------
// Reset values and fixed patterns
// ----------------------------------------------------------------
`define HWM_RST_CHANNEL_MODE 8'h00
`define HWM_RST_MAIN_CONFIG 8'h08
`define HWM_RST_ZERO 8'h00
`define HWM_RST_FANDIV 4'h5
`define HWM_MAIN_CONFIG_WMASK 8'hdf
`define HWM_AUX_CONFIG_WMASK 8'hcf
`define HWM_STB_VALID 8'hf3
`define HWM_VID_HIGH_PAD 7'h40

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define HWM_CLK_HZ 200000000
`define HWM_RESET_PULSE_MS 45
`define HWM_RESET_PULSE_CYC (`HWM_CLK_HZ / 1000 * `HWM_RESET_PULSE_MS)
`define HWM_INTRUSION_PULSE_MS 20
`define HWM_INTRUSION_PULSE_CYC (`HWM_CLK_HZ / 1000 * `HWM_INTRUSION_PULSE_MS)

`endif

/* File: rtl/hwm_regs.v */
// Control, limit and interrupt status register bank of the hardware monitor.
// Assumes a serial bus front end that delivers one-cycle register read and write
// strobes with an 8-bit address; measurement logic reports limit events as pulses.
`timescale 1ns/100ps
`include "hwm_consts.vh"

// What this block does
// RQ1: Mode bits 0 and 1 pick tachometer or analog use of each multi-input.
// RQ2: Mode bit 2 picks supply measurement or second remote diode.
// RQ3: Mode bit 3 picks 3.3 V or 5.0 V internal supply range.
// RQ4: Mode bit 7 turns the identification pins into interrupt inputs.
// RQ5: Mode bits 4 to 6 enable grouped interrupt inputs, only in interrupt use.
// RQ6: Main configuration reads 08h after power-on.
// RQ7: Start bit runs scanning and limit checks; clear means standby.
// RQ8: Clearing start does not release either interrupt output.
// RQ9: Host should load all limits before setting start.
// RQ10: Config bits 1 and 2 enable the request and overtemperature outputs.
// RQ11: Config bit 3 holds request output clear and pauses monitoring.
// RQ12: Config bit 4 fires a 45 ms low reset pulse, then self-clears.
// RQ13: Config bit 6 releases the overtemperature output, status untouched.
// RQ14: Config bit 7 restores defaults of config, status, mask, divisor registers.
// RQ15: Status A holds one error flag per channel, bits 0 to 7.
// RQ16: Temperature flags also set on a temperature interrupt.
// RQ17: Status B holds 12 V, core supply 2, intrusion, overtemp-in, diode faults.
// RQ18: Reading a status register clears the flags it returned.
// RQ19: A channel still faulting raises a fresh flag after the read.
// RQ20: Host may mask a channel that keeps faulting.
// RQ21: Limit registers hold host-written 8-bit high and low limits.
// RQ22: Read-only maker code and part revision registers.
// RQ23: A mask bit of 1 keeps its flag off the request output.
// RQ24: Aux config bit 0 masks thermal flags from request output only.
// RQ25: Request output is low when enabled, not held, and a flag is unmasked.
module hwm_regs #(
    parameter [7:0] MAKER_CODE = 8'h5a,    // Arbitrary value
    parameter [3:0] REVISION = 4'h3,       // Arbitrary value
    parameter RESET_PULSE_CYC = `HWM_RESET_PULSE_CYC,
    parameter INTRUSION_PULSE_CYC = `HWM_INTRUSION_PULSE_CYC
) (
    // Clock and reset
    input wire i_clk,
    input wire i_rst_n,
    // Register access from the serial bus front end
    input wire i_wr,
    input wire i_rd,
    input wire [7:0] i_addr,
    input wire [7:0] i_wdata,
    output reg [7:0] o_rdata,
    // Limit events from the measurement logic, one-cycle pulses
    input wire [7:0] i_err_a,
    input wire [7:0] i_err_b,
    input wire [1:0] i_temp_irq,
    // Pins
    input wire [4:0] i_id_pins,
    input wire i_case_open_input,
    input wire i_overtemp_pin,
    input wire i_overtemp_event,
    // Controls to the measurement logic
    output reg o_monitor_run,
    output reg [7:0] o_channel_mode,
    output reg [2:0] o_ext_irq_on,
    output reg [3:0] o_fan_div,
    output reg [7:0] o_limit_flat_unused_n,
    // Open-drain outputs, enable high while pulling low
    output reg o_irq_oe,
    output reg o_overtemp_oe,
    output reg o_reset_oe,
    output reg o_case_open_oe
);

// ----------------------------------------------------------------
// Storage
// ----------------------------------------------------------------
reg [7:0] channel_mode;
reg [7:0] main_config;
reg [7:0] aux_config;
reg [7:0] irq_status_a;
reg [7:0] irq_status_b;
reg [7:0] irq_mask_a;
reg [7:0] irq_mask_b;
reg [3:0] fan_div;
reg intrusion_clear;
reg overtemp_latched;
reg case_prev;
reg [7:0] limits [0:7];
reg [31:0] reset_cnt;
reg [31:0] intr_cnt;
reg [7:0] next_rdata;
reg [7:0] gated_a;
reg [7:0] gated_b;

function [2:0] limit_index;
    input [7:0] addr;
    begin
        limit_index = addr[2:0] - 3'd5;
    end
endfunction

function is_limit;
    input [7:0] addr;
    begin
        is_limit = (addr >= `HWM_ADDR_CS2_HI) && (addr <= `HWM_ADDR_MI2_HI);
    end
endfunction

wire wr_main = i_wr && (i_addr == `HWM_ADDR_MAIN_CONFIG);
wire soft_init = wr_main && i_wdata[`HWM_CFG_INIT]; // RQ14
wire rd_sta_a = i_rd && (i_addr == `HWM_ADDR_STATUS_A);
wire rd_sta_b = i_rd && (i_addr == `HWM_ADDR_STATUS_B);
// Monitoring pauses while start is low or the request clear is held
wire monitoring = main_config[`HWM_CFG_START] && !main_config[`HWM_CFG_IRQ_CLEAR]; // RQ7 RQ11
wire case_rise = i_case_open_input && !case_prev;
// Grouped pins drive the request output directly, not status, only when the group is in interrupt use
wire ext_irq_any = channel_mode[`HWM_MODE_ID_AS_IRQ] &&
    |(channel_mode[6:4] & i_id_pins[2:0]); // RQ5
// Status sources; temperature interrupts feed the two temperature flags
wire [7:0] set_a = monitoring ? (i_err_a |
    {2'b00, i_temp_irq, 4'h0}) : 8'h00; // RQ15 RQ16
wire [7:0] set_b = monitoring ? ((i_err_b & `HWM_STB_VALID) |
    {2'b00, !i_overtemp_pin, case_rise, 4'h0}) : 8'h00; // RQ17

// ----------------------------------------------------------------
// Configuration and mode registers
// ----------------------------------------------------------------
always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
        channel_mode <= `HWM_RST_CHANNEL_MODE; // RQ1 RQ2 RQ3 RQ4 RQ5
        main_config <= `HWM_RST_MAIN_CONFIG; // RQ6
        aux_config <= `HWM_RST_ZERO;
        irq_mask_a <= `HWM_RST_ZERO;
        irq_mask_b <= `HWM_RST_ZERO;
        fan_div <= `HWM_RST_FANDIV;
        intrusion_clear <= 1'b0;
    end else if (soft_init) begin
        main_config <= `HWM_RST_MAIN_CONFIG; // RQ14
        aux_config <= `HWM_RST_ZERO;
        irq_mask_a <= `HWM_RST_ZERO;
        irq_mask_b <= `HWM_RST_ZERO;
        fan_div <= `HWM_RST_FANDIV;
    end else begin
        if (i_wr && i_addr == `HWM_ADDR_CHANNEL_MODE)
            channel_mode <= i_wdata; // RQ1 RQ2 RQ3 RQ4
        if (wr_main)
            main_config <= i_wdata & `HWM_MAIN_CONFIG_WMASK; // RQ7 RQ10 RQ11
        else if (reset_cnt == 32'd1)
            main_config[`HWM_CFG_RESET_PULSE] <= 1'b0; // RQ12
        if (i_wr && i_addr == `HWM_ADDR_AUX_CONFIG)
            aux_config <= i_wdata & `HWM_AUX_CONFIG_WMASK; // RQ24
        if (i_wr && i_addr == `HWM_ADDR_MASK_A)
            irq_mask_a <= i_wdata; // RQ23
        if (i_wr && i_addr == `HWM_ADDR_MASK_B)
            irq_mask_b <= i_wdata; // RQ23
        if (i_wr && i_addr == `HWM_ADDR_VID_FANDIV)
            fan_div <= i_wdata[7:4];
        if (i_wr && i_addr == `HWM_ADDR_INTRUSION_CLR && i_wdata[`HWM_INTRUSION_CLR_BIT])
            intrusion_clear <= 1'b1;
        else if (intr_cnt == 32'd1)
            intrusion_clear <= 1'b0;
    end
end

// ----------------------------------------------------------------
// Limit registers, no reset: contents are undefined until written
// ----------------------------------------------------------------
always @(posedge i_clk) begin
    if (i_wr && is_limit(i_addr))
        limits[limit_index(i_addr)] <= i_wdata; // RQ21
end

// ----------------------------------------------------------------
// Status flags: set wins over read-clear so a live fault re-flags
// ----------------------------------------------------------------
always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
        irq_status_a <= `HWM_RST_ZERO;
        irq_status_b <= `HWM_RST_ZERO;
        case_prev <= 1'b0;
    end else begin
        case_prev <= i_case_open_input;
        if (soft_init) begin
            irq_status_a <= `HWM_RST_ZERO; // RQ14
            irq_status_b <= `HWM_RST_ZERO;
        end else begin
            irq_status_a <= (rd_sta_a ? 8'h00 : irq_status_a) | set_a; // RQ18 RQ19
            irq_status_b <= (rd_sta_b ? 8'h00 : irq_status_b) | set_b; // RQ18 RQ19
        end
    end
end

// ----------------------------------------------------------------
// Pulse timers for the reset and intrusion pins
// ----------------------------------------------------------------
always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
        reset_cnt <= 32'd0;
        intr_cnt <= 32'd0;
    end else begin
        if (wr_main && i_wdata[`HWM_CFG_RESET_PULSE] && !soft_init)
            reset_cnt <= RESET_PULSE_CYC; // RQ12
        else if (reset_cnt != 32'd0)
            reset_cnt <= reset_cnt - 32'd1;
        if (i_wr && i_addr == `HWM_ADDR_INTRUSION_CLR && i_wdata[`HWM_INTRUSION_CLR_BIT])
            intr_cnt <= INTRUSION_PULSE_CYC;
        else if (intr_cnt != 32'd0)
            intr_cnt <= intr_cnt - 32'd1;
    end
end

// ----------------------------------------------------------------
// Read mux
// ----------------------------------------------------------------
always @* begin
    next_rdata = 8'h00;
    if (is_limit(i_addr))
        next_rdata = limits[limit_index(i_addr)];
    else begin
        case (i_addr)
            `HWM_ADDR_CHANNEL_MODE: next_rdata = channel_mode;
            `HWM_ADDR_MAKER: next_rdata = MAKER_CODE; // RQ22
            `HWM_ADDR_REVISION: next_rdata = {4'h1, REVISION}; // RQ22
            `HWM_ADDR_MAIN_CONFIG: next_rdata = main_config;
            `HWM_ADDR_STATUS_A: next_rdata = irq_status_a; // RQ15
            `HWM_ADDR_STATUS_B: next_rdata = irq_status_b; // RQ17
            `HWM_ADDR_MASK_A: next_rdata = irq_mask_a;
            `HWM_ADDR_MASK_B: next_rdata = irq_mask_b;
            `HWM_ADDR_INTRUSION_CLR: next_rdata = {intrusion_clear, 7'h00};
            `HWM_ADDR_VID_FANDIV: next_rdata = {fan_div, i_id_pins[3:0]};
            `HWM_ADDR_VID_HIGH: next_rdata = {`HWM_VID_HIGH_PAD, i_id_pins[4]};
            `HWM_ADDR_AUX_CONFIG: next_rdata = aux_config;
            `HWM_ADDR_STATUS_A_COPY: next_rdata = irq_status_a;
            `HWM_ADDR_STATUS_B_COPY: next_rdata = irq_status_b;
            default: next_rdata = 8'h00;
        endcase
    end
end

// ----------------------------------------------------------------
// Output flops
// ----------------------------------------------------------------
always @* begin
    gated_a = irq_status_a & ~irq_mask_a; // RQ23
    gated_b = irq_status_b & ~irq_mask_b; // RQ23
    if (aux_config[`HWM_AUX_THERMAL_MASK]) begin
        gated_a[`HWM_STA_INT_TEMP] = 1'b0; // RQ24
        gated_a[`HWM_STA_RD1_TEMP] = 1'b0;
        gated_b[`HWM_STB_OVERTEMP_IN] = 1'b0;
    end
end

always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
        o_rdata <= 8'h00;
        o_monitor_run <= 1'b0;
        o_channel_mode <= `HWM_RST_CHANNEL_MODE;
        o_ext_irq_on <= 3'b000;
        o_fan_div <= `HWM_RST_FANDIV;
        o_limit_flat_unused_n <= 8'hff;
        o_irq_oe <= 1'b0;
        o_overtemp_oe <= 1'b0;
        o_reset_oe <= 1'b0;
        o_case_open_oe <= 1'b0;
        overtemp_latched <= 1'b0;
    end else begin
        o_rdata <= next_rdata;
        o_monitor_run <= monitoring; // RQ7 RQ11
        o_channel_mode <= channel_mode; // RQ1 RQ2 RQ3 RQ4
        o_ext_irq_on <= channel_mode[`HWM_MODE_ID_AS_IRQ] ? channel_mode[6:4] : 3'b000; // RQ5
        o_fan_div <= fan_div;
        o_limit_flat_unused_n <= {7'h7f, !ext_irq_any};
        // Start bit plays no part here, so stopping never releases the pin
        o_irq_oe <= main_config[`HWM_CFG_IRQ_ON] && !main_config[`HWM_CFG_IRQ_CLEAR] &&
            (|gated_a || |gated_b || ext_irq_any); // RQ8 RQ10 RQ11 RQ25
        if (wr_main && i_wdata[`HWM_CFG_OVERTEMP_RELEASE])
            overtemp_latched <= 1'b0; // RQ13
        else if (i_overtemp_event || (|i_temp_irq && monitoring))
            overtemp_latched <= 1'b1;
        o_overtemp_oe <= overtemp_latched && main_config[`HWM_CFG_OVERTEMP_ON]; // RQ8 RQ10
        o_reset_oe <= reset_cnt != 32'd0; // RQ12
        o_case_open_oe <= intr_cnt != 32'd0;
    end
end

endmodule

/* File: verif/hwm_regs_checker.sv */
// Assertion checker for the monitor register bank, bound to its top module.
// Assumes one clock domain and register strobes one cycle long.
`timescale 1ns/100ps
module hwm_regs_checker #(
    parameter [7:0] MAKER_CODE = 8'h5a,
    parameter [3:0] REVISION = 4'h3
) (
    // Clock, reset and register strobes
    input wire i_clk,
    input wire i_rst_n,
    input wire i_wr,
    input wire i_rd,
    input wire [7:0] i_addr,
    input wire [7:0] i_wdata,
    // Outputs under watch
    input wire [7:0] o_rdata,
    input wire o_monitor_run,
    input wire [7:0] o_channel_mode,
    input wire [2:0] o_ext_irq_on,
    input wire o_irq_oe,
    input wire o_reset_oe
);
    reg cfg_start;
    reg cfg_on;
    reg cfg_hold;
    wire cfg_wr = i_wr && i_addr == 8'h40;
    // Soft init brings back the held-clear default, so it is tracked too
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cfg_start <= 1'b0;
            cfg_on <= 1'b0;
            cfg_hold <= 1'b1;
        end else if (cfg_wr) begin
            cfg_start <= i_wdata[0] & ~i_wdata[7];
            cfg_on <= i_wdata[1] & ~i_wdata[7];
            cfg_hold <= i_wdata[3] | i_wdata[7];
        end
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    // --------
    // Properties
    // --------
    // The mode copy on the port trails the stored register by one more edge
    property p_mode; i_wr && i_addr == 8'h16 |=> ##1 o_channel_mode == $past(i_wdata, 2); endproperty
    a_mode: assert property (p_mode) else $error("mode not stored");
    property p_run; (cfg_start && !cfg_hold) [*2] |-> o_monitor_run; endproperty
    a_run: assert property (p_run) else $error("monitor not running");
    property p_stop; (!cfg_start || cfg_hold) [*2] |-> !o_monitor_run; endproperty
    a_stop: assert property (p_stop) else $error("monitor not halted");
    property p_gate; (!cfg_on || cfg_hold) [*2] |=> !o_irq_oe; endproperty
    a_gate: assert property (p_gate) else $error("request output not gated");
    property p_keep; o_irq_oe && cfg_wr && i_wdata == 8'h02 |=> o_irq_oe; endproperty
    a_keep: assert property (p_keep) else $error("request released by stop");
    property p_ext; o_channel_mode == $past(o_channel_mode) |->
        o_ext_irq_on == (o_channel_mode[7] ? o_channel_mode[6:4] : 3'b000); endproperty
    a_ext: assert property (p_ext) else $error("grouped enables wrong");
    property p_maker; i_rd && i_addr == 8'h3e |=> o_rdata == MAKER_CODE; endproperty
    a_maker: assert property (p_maker) else $error("maker code wrong");
    property p_rev; i_rd && i_addr == 8'h3f |=> o_rdata == {4'h1, REVISION}; endproperty
    a_rev: assert property (p_rev) else $error("revision wrong");
    property p_pulse; cfg_wr && i_wdata[4] && !i_wdata[7] |=> ##1 o_reset_oe [*8]; endproperty
    a_pulse: assert property (p_pulse) else $error("reset pulse missing");
endmodule
bind hwm_regs hwm_regs_checker #(.MAKER_CODE(MAKER_CODE), .REVISION(REVISION)) u_chk (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_wr(i_wr), .i_rd(i_rd), .i_addr(i_addr),
    .i_wdata(i_wdata), .o_rdata(o_rdata), .o_monitor_run(o_monitor_run),
    .o_channel_mode(o_channel_mode), .o_ext_irq_on(o_ext_irq_on), .o_irq_oe(o_irq_oe),
    .o_reset_oe(o_reset_oe));

/* File: verif/hwm_host.sv */
// Host model on the register strobe bus: one-cycle read and write strobes.
// Assumes the bank samples on the rising edge and answers one cycle later.
`timescale 1ns/100ps
module hwm_host (
    // Clock
    input wire i_clk,
    // Strobe bus
    output reg o_wr = 1'b0,
    output reg o_rd = 1'b0,
    output reg [7:0] o_addr = 8'h00,
    output reg [7:0] o_wdata = 8'h00,
    input wire [7:0] i_rdata
);
    task wr(input [7:0] a, input [7:0] d);
        begin
            @(negedge i_clk);
            o_wr = 1'b1;
            o_addr = a;
            o_wdata = d;
            @(negedge i_clk);
            o_wr = 1'b0;
            // Stale data is inverted so nothing relies on it
            o_wdata = ~d;
        end
    endtask
    task rd(input [7:0] a, output [7:0] d);
        begin
            @(negedge i_clk);
            o_rd = 1'b1;
            o_addr = a;
            @(negedge i_clk);
            o_rd = 1'b0;
            d = i_rdata;
        end
    endtask
endmodule

/* File: verif/hwm_regs_tb.sv */
// Self-checking bench for the monitor register bank.
// Assumes the host model drives the strobe bus; pulse counts are shortened.
`timescale 1ns/100ps
module hwm_regs_tb;
    localparam [7:0] MAKER = 8'h5a; // Arbitrary value
    localparam [3:0] REV = 4'h3; // Arbitrary value
    reg i_clk = 1'b0;
    reg i_rst_n = 1'b0;
    reg [7:0] i_err_a = 8'h00;
    reg [7:0] i_err_b = 8'h00;
    reg [1:0] i_temp_irq = 2'b00;
    reg [4:0] i_id_pins = 5'h0a;
    reg i_case_open_input = 1'b0;
    reg i_overtemp_pin = 1'b1;
    reg i_overtemp_event = 1'b0;
    wire i_wr, i_rd, o_monitor_run, o_irq_oe, o_overtemp_oe, o_reset_oe, o_case_open_oe;
    wire [7:0] i_addr, i_wdata, o_rdata, o_channel_mode, o_limit_flat_unused_n;
    wire [2:0] o_ext_irq_on;
    wire [3:0] o_fan_div;
    reg [7:0] got;
    reg [7:0] a;
    integer bad_count = 0;
    integer n_tests = 0;
    integer n;
    hwm_host u_host (.i_clk(i_clk), .o_wr(i_wr), .o_rd(i_rd), .o_addr(i_addr),
        .o_wdata(i_wdata), .i_rdata(o_rdata));
    hwm_regs #(.MAKER_CODE(MAKER), .REVISION(REV), .RESET_PULSE_CYC(20),
        .INTRUSION_PULSE_CYC(10)) uut (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_wr(i_wr), .i_rd(i_rd), .i_addr(i_addr),
        .i_wdata(i_wdata), .o_rdata(o_rdata), .i_err_a(i_err_a), .i_err_b(i_err_b),
        .i_temp_irq(i_temp_irq), .i_id_pins(i_id_pins), .i_case_open_input(i_case_open_input),
        .i_overtemp_pin(i_overtemp_pin), .i_overtemp_event(i_overtemp_event),
        .o_monitor_run(o_monitor_run), .o_channel_mode(o_channel_mode),
        .o_ext_irq_on(o_ext_irq_on), .o_fan_div(o_fan_div),
        .o_limit_flat_unused_n(o_limit_flat_unused_n), .o_irq_oe(o_irq_oe),
        .o_overtemp_oe(o_overtemp_oe), .o_reset_oe(o_reset_oe),
        .o_case_open_oe(o_case_open_oe));
    task ck(input string what, input [7:0] exp, input [7:0] seen);
        begin
            n_tests = n_tests + 1;
            if (seen !== exp) begin
                bad_count = bad_count + 1;
                $display("BAD %s expected %h seen %h", what, exp, seen);
            end
        end
    endtask
    task rc(input [7:0] addr, input [7:0] exp);
        begin
            u_host.rd(addr, got);
            ck($sformatf("reg %h", addr), exp, got);
        end
    endtask
    // One-cycle event pulses, then two cycles for flags to reach the pins
    task ev(input [7:0] ea, input [7:0] eb, input [1:0] t);
        begin
            @(negedge i_clk);
            {i_err_a, i_err_b, i_temp_irq} = {ea, eb, t};
            @(negedge i_clk);
            {i_err_a, i_err_b, i_temp_irq} = 18'h00000;
            repeat (2) @(negedge i_clk);
        end
    endtask
    task end_sim;
        begin
            $display("checks %0d mismatches %0d", n_tests, bad_count);
            if (bad_count == 0 && n_tests > 0) $display("[ PASS ]");
            else $display("[ FAIL ]");
            $finish;
        end
    endtask
    // --------
    // Scenarios
    // --------
    task t_reset;
        begin
            rc(8'h40, 8'h08);
            rc(8'h16, 8'h00);
            rc(8'h44, 8'h00);
            rc(8'h3e, MAKER);
            rc(8'h3f, {4'h1, REV});
            rc(8'h47, {4'h5, i_id_pins[3:0]});
            rc(8'h3d, 8'h00);
            $display("test reset done");
        end
    endtask
    task t_mode_limits;
        begin
            i_id_pins = 5'h1f;
            for (n = 0; n < 8; n = n + 1) begin
                u_host.wr(8'h16, 8'h01 << n);
                @(negedge i_clk);
                ck("mode", 8'h01 << n, o_channel_mode);
            end
            u_host.wr(8'h16, 8'h70);
            @(negedge i_clk);
            ck("group_off", 8'h01, {4'h0, o_ext_irq_on, o_limit_flat_unused_n[0]});
            u_host.wr(8'h16, 8'hf0);
            @(negedge i_clk);
            ck("group_on", 8'h0e, {4'h0, o_ext_irq_on, o_limit_flat_unused_n[0]});
            u_host.wr(8'h16, 8'h00);
            for (a = 8'h35; a < 8'h3d; a = a + 8'h01) u_host.wr(a, a ^ 8'ha5);
            for (a = 8'h35; a < 8'h3d; a = a + 8'h01) rc(a, a ^ 8'ha5);
            $display("test mode and limits done");
        end
    endtask
    task t_status;
        begin
            u_host.wr(8'h40, 8'h03);
            ev(8'h81, 8'h00, 2'b00);
            ck("irq", 8'h01, {7'h00, o_irq_oe});
            rc(8'h41, 8'h81);
            fork
                u_host.rd(8'h41, got);
                ev(8'h02, 8'h00, 2'b00);
            join
            ck("cleared", 8'h00, got);
            rc(8'h41, 8'h02);
            u_host.wr(8'h43, 8'h01);
            ev(8'h01, 8'h00, 2'b00);
            ck("masked", 8'h00, {7'h00, o_irq_oe});
            rc(8'h41, 8'h01);
            u_host.wr(8'h43, 8'h00);
            ev(8'h00, 8'hcf, 2'b11);
            rc(8'h41, 8'h30);
            rc(8'h42, 8'hc3);
            @(negedge i_clk);
            {i_case_open_input, i_overtemp_pin} = 2'b10;
            @(negedge i_clk);
            i_overtemp_pin = 1'b1;
            rc(8'h42, 8'h30);
            $display("test status done");
        end
    endtask
    task t_control;
        begin
            ev(8'h01, 8'h00, 2'b00);
            u_host.wr(8'h40, 8'h02);
            @(negedge i_clk);
            ck("irq_kept", 8'h01, {7'h00, o_irq_oe});
            u_host.wr(8'h40, 8'h0a);
            @(negedge i_clk);
            ck("irq_held", 8'h00, {7'h00, o_irq_oe});
            rc(8'h41, 8'h01);
            u_host.wr(8'h4a, 8'h01);
            u_host.wr(8'h40, 8'h07);
            ev(8'h00, 8'h00, 2'b01);
            ck("thermal", 8'h00, {7'h00, o_irq_oe});
            rc(8'h41, 8'h10);
            @(negedge i_clk);
            i_overtemp_event = 1'b1;
            @(negedge i_clk);
            i_overtemp_event = 1'b0;
            @(negedge i_clk);
            ck("overtemp", 8'h01, {7'h00, o_overtemp_oe});
            u_host.wr(8'h40, 8'h47);
            @(negedge i_clk);
            ck("overtemp_rel", 8'h00, {7'h00, o_overtemp_oe});
            $display("test control done");
        end
    endtask
    task t_pulse_init;
        begin
            u_host.wr(8'h40, 8'h10);
            n = 0;
            repeat (40) begin
                if (o_reset_oe === 1'b1) n = n + 1;
                @(negedge i_clk);
            end
            ck("pulse_len", 8'h14, n[7:0]);
            rc(8'h40, 8'h00);
            u_host.wr(8'h43, 8'hff);
            u_host.wr(8'h47, 8'hf0);
            u_host.wr(8'h40, 8'h80);
            rc(8'h40, 8'h08);
            rc(8'h43, 8'h00);
            rc(8'h4a, 8'h00);
            ck("fan_div", 8'h05, {4'h0, o_fan_div});
            u_host.wr(8'h46, 8'h80);
            n = 0;
            repeat (30) begin
                if (o_case_open_oe === 1'b1) n = n + 1;
                @(negedge i_clk);
            end
            ck("intr_pulse_len", 8'h0a, n[7:0]);
            rc(8'h46, 8'h00);
            $display("test pulse and init done");
        end
    endtask
    initial begin
        forever #2.5 i_clk = ~i_clk;
    end
    initial begin
        repeat (5) @(negedge i_clk);
        i_rst_n = 1'b1;
        t_reset;
        t_mode_limits;
        t_status;
        t_control;
        t_pulse_init;
        end_sim;
    end
    // About seventeen times the expected run, so a hung handshake still ends the run
    initial begin
        #20000;
        bad_count = bad_count + 1;
        end_sim;
    end
endmodule
